// *** hw/irc_codec.sv ***
// Purpose: infrared remote codec, NEC and Sony receive, Sony transmit
// Assumes: ir_rx_n is the active-low demodulated output of a receiver module
// Notes: one microsecond tick drives every mark and space duration; the carrier counts clock cycles; US_CYC shortens the tick
`timescale 1ns/1ps
module irc_codec #(
    parameter int US_CYC = irc_pkg::US_CYC,
    parameter int FRAME_US = irc_pkg::FRAME_US
)(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Receiver module output, low during a mark
    input wire logic ir_rx_n,
    // Decoder control
    input wire logic decoder_shutdown_command,
    input wire logic decoder_start_command,
    output logic rx_running,
    // Decoder report
    output irc_pkg::irc_codes_t rx_codes,
    output logic rx_event,
    // Transmit request and LED drive
    input wire logic infrared_transmit_command,
    input irc_pkg::irc_tx_req_t tx_req,
    output logic tx_busy,
    output logic ir_tx
);
    // ==========================================================
    // Microsecond timebase
    logic [15:0] tick_cnt, next_tick_cnt;
    logic us_tick;

    always_comb
    begin
        us_tick = (tick_cnt == 16'(US_CYC - 1));
        next_tick_cnt = us_tick ? 16'h0 : tick_cnt + 16'h1;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            tick_cnt <= 16'h0;
        else
            tick_cnt <= next_tick_cnt;
    end

    // ==========================================================
    // Receive decoder
    logic rx_s1, rx_s2, rx_d;
    irc_pkg::irc_rx_state_t state, next_state;
    logic [15:0] dur, next_dur;
    logic [31:0] shreg, next_shreg;
    logic [5:0] bitn, next_bitn;
    logic have_nec, next_have_nec;
    logic next_running;
    irc_pkg::irc_codes_t next_rx_codes;
    logic next_rx_event;
    logic mark, mark_end, space_end;
    logic [11:0] sony_word;
    logic nec_bit;

    always_comb
    begin
        next_state = state;
        next_shreg = shreg;
        next_bitn = bitn;
        next_have_nec = have_nec;
        next_rx_codes = rx_codes;
        next_rx_event = 1'h0;
        nec_bit = 1'h0;
        mark = !rx_s2;
        mark_end = !rx_d && !mark;
        space_end = rx_d && mark;
        // Sony sends key LSB first, then device; shift right so it lands in place
        sony_word = {irc_pkg::irc_in_win(dur, irc_pkg::SONY_ONE_LO, irc_pkg::SONY_ONE_HI), shreg[11:1]};
        // Duration of the current mark or space, saturating
        if (mark_end || space_end)
            next_dur = 16'h0;
        else if (us_tick && dur != 16'hFFFF)
            next_dur = dur + 16'h1;
        else
            next_dur = dur;
        // Shutdown beats a simultaneous start
        next_running = rx_running;
        if (decoder_start_command)
            next_running = 1'h1;
        if (decoder_shutdown_command)
            next_running = 1'h0;
        if (!rx_running)
            next_state = irc_pkg::RX_IDLE;
        else if (state != irc_pkg::RX_IDLE && !mark && int'(dur) >= irc_pkg::RX_TIMEOUT_US)
            next_state = irc_pkg::RX_IDLE;
        else if (mark_end)
            case (state)
                irc_pkg::RX_IDLE:
                    if (irc_pkg::irc_in_win(dur, irc_pkg::NEC_LEAD_LO, irc_pkg::NEC_LEAD_HI))
                        next_state = irc_pkg::RX_HDR;
                    else if (irc_pkg::irc_in_win(dur, irc_pkg::SONY_START_LO, irc_pkg::SONY_START_HI))
                    begin
                        next_state = irc_pkg::RX_SONY;
                        next_bitn = 6'h0;
                    end
                irc_pkg::RX_NEC:
                begin
                    next_state = irc_pkg::RX_NEC;
                    if (!irc_pkg::irc_in_win(dur, irc_pkg::NEC_UNIT_LO, irc_pkg::NEC_UNIT_HI))
                        next_state = irc_pkg::RX_IDLE;
                    else if (bitn == 6'(irc_pkg::NEC_BITS))
                    begin
                        next_state = irc_pkg::RX_IDLE;
                        // Key byte must match its complement or the frame is dropped
                        if (shreg[15:8] == ~shreg[7:0])
                        begin
                            next_rx_codes.dev = shreg[31:24];
                            next_rx_codes.key = shreg[15:8];
                            next_rx_event = 1'h1;
                            next_have_nec = 1'h1;
                        end
                    end
                end
                irc_pkg::RX_RPT:
                begin
                    next_state = irc_pkg::RX_IDLE;
                    // Repeat keeps the held key alive; no prior frame, no event
                    if (have_nec && irc_pkg::irc_in_win(dur, irc_pkg::NEC_UNIT_LO, irc_pkg::NEC_UNIT_HI))
                        next_rx_event = 1'h1;
                end
                irc_pkg::RX_SONY:
                    if (irc_pkg::irc_in_win(dur, irc_pkg::SONY_UNIT_LO, irc_pkg::SONY_UNIT_HI)
                        || irc_pkg::irc_in_win(dur, irc_pkg::SONY_ONE_LO, irc_pkg::SONY_ONE_HI))
                    begin
                        next_shreg = {20'h0, sony_word};
                        next_bitn = bitn + 6'h1;
                        if (bitn == 6'(irc_pkg::SONY_BITS - 1))
                        begin
                            next_state = irc_pkg::RX_IDLE;
                            next_rx_codes.dev = {3'h0, sony_word[11:7]};
                            next_rx_codes.key = {1'h0, sony_word[6:0]};
                            next_rx_event = 1'h1;
                        end
                    end
                    else
                        next_state = irc_pkg::RX_IDLE;
                default:
                    next_state = irc_pkg::RX_IDLE;
            endcase
        else if (space_end)
            case (state)
                irc_pkg::RX_HDR:
                    if (irc_pkg::irc_in_win(dur, irc_pkg::NEC_HDR_LO, irc_pkg::NEC_HDR_HI))
                    begin
                        next_state = irc_pkg::RX_NEC;
                        next_bitn = 6'h0;
                    end
                    else if (irc_pkg::irc_in_win(dur, irc_pkg::NEC_RPT_LO, irc_pkg::NEC_RPT_HI))
                        next_state = irc_pkg::RX_RPT;
                    else
                        next_state = irc_pkg::RX_IDLE;
                irc_pkg::RX_NEC:
                begin
                    nec_bit = irc_pkg::irc_in_win(dur, irc_pkg::NEC_ONE_LO, irc_pkg::NEC_ONE_HI);
                    if (bitn == 6'(irc_pkg::NEC_BITS)
                        || !(nec_bit || irc_pkg::irc_in_win(dur, irc_pkg::NEC_UNIT_LO, irc_pkg::NEC_UNIT_HI)))
                        next_state = irc_pkg::RX_IDLE;
                    else
                    begin
                        // Shift left: first bit on air ends up as the byte MSB
                        next_shreg = {shreg[30:0], nec_bit};
                        next_bitn = bitn + 6'h1;
                    end
                end
                irc_pkg::RX_SONY:
                    if (!irc_pkg::irc_in_win(dur, irc_pkg::SONY_UNIT_LO, irc_pkg::SONY_UNIT_HI))
                        next_state = irc_pkg::RX_IDLE;
                irc_pkg::RX_IDLE:
                    next_state = irc_pkg::RX_IDLE;
                default:
                    next_state = irc_pkg::RX_IDLE;
            endcase
    end

    // Receive registers; the pin passes two flops before any logic sees it
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rx_s1 <= 1'h1;
            rx_s2 <= 1'h1;
            rx_d <= 1'h1;
            state <= irc_pkg::RX_IDLE;
            dur <= 16'h0;
            shreg <= 32'h0;
            bitn <= 6'h0;
            have_nec <= 1'h0;
            rx_running <= 1'h1;
            rx_codes <= '0;
            rx_event <= 1'h0;
        end
        else
        begin
            rx_s1 <= ir_rx_n;
            rx_s2 <= rx_s1;
            rx_d <= rx_s2;
            state <= next_state;
            dur <= next_dur;
            shreg <= next_shreg;
            bitn <= next_bitn;
            have_nec <= next_have_nec;
            rx_running <= next_running;
            rx_codes <= next_rx_codes;
            rx_event <= next_rx_event;
        end
    end

    // ==========================================================
    // Transmitter
    irc_sony_tx #(
        .FRAME_US(FRAME_US)
    ) u_tx (
        .clk(clk),
        .arst_n(arst_n),
        .us_tick(us_tick),
        .infrared_transmit_command(infrared_transmit_command),
        .tx_req(tx_req),
        .tx_busy(tx_busy),
        .ir_tx(ir_tx)
    );

    // ==========================================================
    // Checks
    a_rx_closed_quiet: assert property (@(posedge clk) disable iff (!arst_n)
        (!rx_running && !decoder_start_command) |=> !rx_event && $stable(rx_codes))
        else $error("event while decoder shut down");
    a_rx_codes_event: assert property (@(posedge clk) disable iff (!arst_n)
        !$stable(rx_codes) |-> rx_event) else $error("codes changed without event");
    a_rx_timeout_drop: assert property (@(posedge clk) disable iff (!arst_n)
        (state != irc_pkg::RX_IDLE && !mark && dur == 16'(irc_pkg::RX_TIMEOUT_US)) |=> state == irc_pkg::RX_IDLE)
        else $error("stalled frame not dropped");
    a_rx_event_pulse: assert property (@(posedge clk) disable iff (!arst_n)
        rx_event |=> !rx_event [*4]) else $error("event longer than one cycle");
endmodule // irc_codec

// *** hw/irc_sony_tx.sv ***
// Purpose: Sony 12-bit frame transmitter with 38 kHz carrier
// Assumes: us_tick is a one-cycle pulse every microsecond
// Notes: busy covers the whole fixed frame period, not just the marks
`timescale 1ns/1ps
module irc_sony_tx #(
    parameter int FRAME_US = irc_pkg::FRAME_US
)(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Timebase
    input wire logic us_tick,
    // Request
    input wire logic infrared_transmit_command,
    input irc_pkg::irc_tx_req_t tx_req,
    output logic tx_busy,
    // LED drive
    output logic ir_tx
);
    irc_pkg::irc_tx_state_t state, next_state;
    logic [15:0] seg_us, next_seg_us;
    logic [15:0] frame_us, next_frame_us;
    logic [11:0] bits, next_bits;
    logic [3:0] bitn, next_bitn;
    logic start, next_start;
    logic [11:0] car, next_car;
    logic next_ir_tx;
    logic [15:0] seg_len;
    logic seg_end;

    // ==========================================================
    // Sequencer
    always_comb
    begin
        next_state = state;
        next_seg_us = seg_us;
        next_frame_us = frame_us;
        next_bits = bits;
        next_bitn = bitn;
        next_start = start;
        if (state == irc_pkg::TX_MARK)
            seg_len = start ? 16'(irc_pkg::SONY_START_US)
                : (bits[0] ? 16'(irc_pkg::SONY_ONE_US) : 16'(irc_pkg::SONY_UNIT_US));
        else
            seg_len = 16'(irc_pkg::SONY_UNIT_US);
        seg_end = us_tick && (seg_us == seg_len - 16'h1);
        if (us_tick)
        begin
            next_seg_us = seg_end ? 16'h0 : seg_us + 16'h1;
            next_frame_us = frame_us + 16'h1;
        end
        case (state)
            irc_pkg::TX_IDLE:
                if (infrared_transmit_command)
                begin
                    next_state = irc_pkg::TX_MARK;
                    next_start = 1'h1;
                    next_bits = {tx_req.dev, tx_req.key}; // Key LSB goes out first
                    next_bitn = 4'h0;
                    next_seg_us = 16'h0;
                    next_frame_us = 16'h0;
                end
            irc_pkg::TX_MARK:
                if (seg_end)
                begin
                    next_start = 1'h0;
                    next_state = irc_pkg::TX_SPACE;
                    if (!start)
                    begin
                        next_bits = {1'h0, bits[11:1]};
                        next_bitn = bitn + 4'h1;
                        if (bitn == 4'(irc_pkg::SONY_BITS - 1))
                            next_state = irc_pkg::TX_TAIL;
                    end
                end
            irc_pkg::TX_SPACE:
                if (seg_end)
                    next_state = irc_pkg::TX_MARK;
            irc_pkg::TX_TAIL:
                // Hold busy until the fixed frame period has run out
                if (us_tick && frame_us >= 16'(FRAME_US - 1))
                    next_state = irc_pkg::TX_IDLE;
            default:
                next_state = irc_pkg::TX_IDLE;
        endcase
        // Carrier runs only inside marks; idle level is low
        next_car = (next_state != irc_pkg::TX_MARK || car == 12'(irc_pkg::CAR_CYC - 1)) ? 12'h0 : car + 12'h1;
        next_ir_tx = (next_state == irc_pkg::TX_MARK) && (next_car < 12'(irc_pkg::CAR_HALF));
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= irc_pkg::TX_IDLE;
            seg_us <= 16'h0;
            frame_us <= 16'h0;
            bits <= 12'h0;
            bitn <= 4'h0;
            start <= 1'h0;
            car <= 12'h0;
            ir_tx <= 1'h0;
        end
        else
        begin
            state <= next_state;
            seg_us <= next_seg_us;
            frame_us <= next_frame_us;
            bits <= next_bits;
            bitn <= next_bitn;
            start <= next_start;
            car <= next_car;
            ir_tx <= next_ir_tx;
        end
    end

    assign tx_busy = (state != irc_pkg::TX_IDLE);

    // ==========================================================
    // Checks
    a_tx_idle_low: assert property (@(posedge clk) disable iff (!arst_n)
        ir_tx |-> state == irc_pkg::TX_MARK) else $error("LED lit outside a mark");
    a_tx_req_taken: assert property (@(posedge clk) disable iff (!arst_n)
        (infrared_transmit_command && !tx_busy) |=> tx_busy ##1 tx_busy) else $error("send request not taken");
    a_tx_twelve_bits: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(tx_busy) |-> $past(bitn) == 4'hC) else $error("frame ended without twelve bits");
    a_tx_frame_len: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(tx_busy) |-> $past(frame_us) >= 16'(FRAME_US - 1)) else $error("busy dropped early");
    a_tx_carrier_half: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(ir_tx) |-> ir_tx [*8]) else $error("carrier high phase too short");
endmodule // irc_sony_tx

// *** inc/irc_pkg.sv ***
// Purpose: shared constants and types for the infrared remote codec
// Assumes: 100 MHz clock, timings kept in microseconds
// Notes: receive windows are tolerance bands around nominal figures
package irc_pkg;
    // ==========================================================
    // Clock and derived rates
    localparam int CLK_HZ = 100000000;
    localparam int CLK_NS = 10;
    localparam int US_NS = 1000;
    localparam int US_CYC = US_NS / CLK_NS; // Cycles per microsecond tick
    localparam int CARRIER_HZ = 38000;
    localparam int CAR_CYC = CLK_HZ / CARRIER_HZ; // Carrier period, rounded down
    localparam int CAR_HALF = CAR_CYC / 2;

    // ==========================================================
    // Frame timing in microseconds, and frame bit counts
    localparam int FRAME_US = 25000;
    localparam int RX_TIMEOUT_US = 12000;
    localparam int SONY_START_US = 2400;
    localparam int SONY_UNIT_US = 600;
    localparam int SONY_ONE_US = 1200;
    localparam int SONY_BITS = 12;
    localparam int NEC_BITS = 32;

    // ==========================================================
    // Receive tolerance windows, low and high bounds in microseconds
    localparam int NEC_LEAD_LO = 8000;
    localparam int NEC_LEAD_HI = 10000;
    localparam int NEC_HDR_LO = 3500;
    localparam int NEC_HDR_HI = 5500;
    localparam int NEC_RPT_LO = 1800;
    localparam int NEC_RPT_HI = 2700;
    localparam int NEC_UNIT_LO = 400;
    localparam int NEC_UNIT_HI = 750;
    localparam int NEC_ONE_LO = 1400;
    localparam int NEC_ONE_HI = 1900;
    localparam int SONY_START_LO = 2000;
    localparam int SONY_START_HI = 2800;
    localparam int SONY_UNIT_LO = 400;
    localparam int SONY_UNIT_HI = 800;
    localparam int SONY_ONE_LO = 1000;
    localparam int SONY_ONE_HI = 1400;

    // ==========================================================
    // Types
    typedef struct packed {
        logic [7:0] dev;
        logic [7:0] key;
    } irc_codes_t;

    typedef struct packed {
        logic [4:0] dev;
        logic [6:0] key;
    } irc_tx_req_t;

    typedef enum logic [2:0] {RX_IDLE, RX_HDR, RX_NEC, RX_RPT, RX_SONY} irc_rx_state_t;
    typedef enum logic [1:0] {TX_IDLE, TX_MARK, TX_SPACE, TX_TAIL} irc_tx_state_t;

    // Duration test against a window
    function automatic logic irc_in_win(input logic [15:0] d, input int lo, input int hi);
        irc_in_win = (int'(d) >= lo) && (int'(d) <= hi);
    endfunction
endpackage

// *** verif/infrared_remote_codec_tb.sv ***
// Purpose: self-checking bench for the infrared remote codec
// Assumes: one microsecond tick per clock to keep frames short
// Notes: receive expectations go through a queue checked on each event
`timescale 1ns/1ps
module infrared_remote_codec_tb;
    // ==========================================================
    // Parameters and signals
    localparam int US_CYC = 1;
    localparam int FRAME_US = 25000;
    logic clk;
    logic arst_n;
    logic ir_rx_n;
    logic decoder_shutdown_command;
    logic decoder_start_command;
    logic rx_running;
    irc_pkg::irc_codes_t rx_codes;
    logic rx_event;
    logic infrared_transmit_command;
    irc_pkg::irc_tx_req_t tx_req;
    logic tx_busy;
    logic ir_tx;
    int lit_count;
    logic [11:0] tx_word;
    int num_errors = 0;
    int samples_checked = 0;
    int hrun = 0;
    logic [31:0] seed = 32'h3e63;
    irc_pkg::irc_codes_t exp_q[$];

    // ==========================================================
    // Design, far-side model and clock
    irc_codec #(.US_CYC(US_CYC), .FRAME_US(FRAME_US)) dut_u (
        .clk(clk), .arst_n(arst_n), .ir_rx_n(ir_rx_n),
        .decoder_shutdown_command(decoder_shutdown_command), .decoder_start_command(decoder_start_command),
        .rx_running(rx_running), .rx_codes(rx_codes), .rx_event(rx_event),
        .infrared_transmit_command(infrared_transmit_command), .tx_req(tx_req), .tx_busy(tx_busy), .ir_tx(ir_tx)
    );
    irc_ir_link_model #(.US_CYC(US_CYC)) model_u (
        .clk(clk), .ir_rx_n(ir_rx_n), .ir_tx(ir_tx), .lit_count(lit_count), .tx_word(tx_word)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ==========================================================
    // Helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) r[i] = v[7 - i];
        return r;
    endfunction

    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1)
        begin
            num_errors++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // One-cycle command pulse, raised 1 ns after an edge
    task automatic pulse(input int which);
        @(posedge clk);
        #1;
        if (which == 0) decoder_shutdown_command = 1'b1;
        else decoder_start_command = 1'b1;
        @(posedge clk);
        #1;
        decoder_shutdown_command = 1'b0;
        decoder_start_command = 1'b0;
        @(posedge clk);
        #1;
    endtask

    // ==========================================================
    // Receive watcher: every event must match the oldest expectation
    always @(negedge clk)
    begin
        if (rx_event === 1'b1)
        begin
            if (exp_q.size() == 0)
                check(1'b0, "key event with none expected");
            else
                check(rx_codes === exp_q.pop_front(), "received codes differ");
        end
    end

    // Transmit line watcher: idle low, and no lit stretch beyond half a carrier period
    always @(negedge clk)
    begin
        hrun = (ir_tx === 1'b1) ? hrun + 1 : 0;
        if (ir_tx !== 1'b0 && tx_busy !== 1'b1)
            check(1'b0, "LED drive not low while idle");
        if (hrun > irc_pkg::CAR_HALF + 2)
            check(1'b0, "LED drive high past carrier half period");
    end

    // ==========================================================
    // One send, a refused request in mid-frame, then the busy length
    task automatic tx_frame();
        int n;
        int lits;
        logic [11:0] sent;
        seed = lfsr_next(seed);
        lits = lit_count;
        @(posedge clk);
        #1;
        tx_req.dev = seed[4:0];
        tx_req.key = seed[14:8];
        sent = tx_req;
        infrared_transmit_command = 1'b1;
        @(posedge clk);
        #1;
        infrared_transmit_command = 1'b0;
        check(tx_busy === 1'b1 && ir_tx === 1'b1, "send did not start");
        repeat (1000) @(posedge clk);
        #1;
        infrared_transmit_command = 1'b1;
        @(posedge clk);
        #1;
        infrared_transmit_command = 1'b0;
        n = 1002;
        while (tx_busy === 1'b1 && n < FRAME_US * US_CYC + 50)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        check(n >= FRAME_US * US_CYC - 3 && n <= FRAME_US * US_CYC + 3, "busy length wrong");
        check(lit_count - lits >= 13, "too few lit pulses in frame");
        check(tx_word === sent, "sent frame bits differ");
        repeat (200) @(posedge clk);
        #1;
        check(tx_busy === 1'b0 && ir_tx === 1'b0, "refused request was sent");
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        arst_n = 1'b0;
        decoder_shutdown_command = 1'b0;
        decoder_start_command = 1'b0;
        infrared_transmit_command = 1'b0;
        tx_req = '0;
        repeat (20) @(posedge clk);
        #1;
        arst_n = 1'b1;
        check(rx_running === 1'b1 && rx_codes === 16'h0000 && tx_busy === 1'b0, "reset values");
        fork
            tx_frame();
            begin
                seed = lfsr_next(seed);
                exp_q.push_back({rev8(seed[7:0]), rev8(seed[15:8])});
                exp_q.push_back({rev8(seed[7:0]), rev8(seed[15:8])});
                model_u.send_nec(seed[7:0], seed[15:8]);
                model_u.send_rpt();
            end
        join
        seed = lfsr_next(seed);
        exp_q.push_back({3'h0, seed[4:0], 1'b0, seed[14:8]});
        model_u.send_sony(seed[14:8], seed[4:0], 12, 0);
        pulse(0);
        check(rx_running === 1'b0, "decoder still running");
        model_u.send_sony(7'h00, 5'h00, 12, 0);
        pulse(1);
        check(rx_running === 1'b1, "decoder did not restart");
        exp_q.push_back({8'h1F, 8'h40});
        model_u.send_sony(7'h40, 5'h1F, 12, 0);
        model_u.send_sony(7'h00, 5'h00, 12, 900);
        repeat (500) @(posedge clk);
        check(exp_q.size() == 0, "expected key events missing");
        results();
    end

    // Hang guard
    initial
    begin
        repeat (170000) @(posedge clk);
        check(1'b0, "run did not finish in time");
        results();
    end
endmodule // infrared_remote_codec_tb

// *** verif/irc_ir_link_model.sv ***
// Purpose: far side of the codec: receiver module output and a lit-LED counter
// Assumes: durations in microseconds, US_CYC clock cycles per microsecond
// Notes: receiver output has a pull-up, so it rests high between marks
`timescale 1ns/1ps
module irc_ir_link_model #(
    parameter int US_CYC = 1
)(
    // Clock
    input wire logic clk,
    // Receiver module output, low during a mark
    output logic ir_rx_n,
    // LED drive from the codec and count of light pulses seen
    input wire logic ir_tx,
    output int lit_count,
    output logic [11:0] tx_word
);
    // ==========================================================
    // Idle state and LED pulse counter
    int lit_num = 0;
    int hi_len = 0;

    initial ir_rx_n = 1'b1;

    always @(posedge ir_tx) lit_num <= lit_num + 1;
    assign lit_count = lit_num;

    // Frame rebuilt from the width of each lit stretch; the start stretch shifts out last
    // Only valid while every data mark is shorter than half a carrier period (fast tick)
    always @(negedge clk)
    begin
        if (ir_tx === 1'b1)
            hi_len <= hi_len + 1;
        else if (hi_len > 0)
        begin
            hi_len <= 0;
            tx_word <= {hi_len > 900 * US_CYC, tx_word[11:1]};
        end
    end

    // ==========================================================
    // Line levels, changed 1 ns after a rising edge
    task automatic hold(input logic lvl, input int us);
        ir_rx_n = lvl;
        repeat (us * US_CYC) @(posedge clk);
        #1;
    endtask

    // NEC frame, bytes sent LSB first; durations sit inside the tolerances
    task automatic send_nec(input logic [7:0] addr, input logic [7:0] cmd);
        logic [31:0] w;
        w = {~cmd, cmd, ~addr, addr};
        hold(1'b0, 8300);
        hold(1'b1, 3700);
        for (int i = 0; i < 32; i++)
        begin
            hold(1'b0, 450);
            hold(1'b1, w[i] ? 1450 : 450);
        end
        hold(1'b0, 450);
        hold(1'b1, 300);
    endtask

    // NEC repeat burst for a held key
    task automatic send_rpt();
        hold(1'b0, 8300);
        hold(1'b1, 2000);
        hold(1'b0, 450);
        hold(1'b1, 300);
    endtask

    // Sony frame, key bits then device bits, LSB first; bad_mark breaks bit 0
    task automatic send_sony(input logic [6:0] key, input logic [4:0] dev, input int nbits, input int bad_mark);
        logic [11:0] w;
        w = {dev, key};
        hold(1'b0, 2100);
        for (int i = 0; i < nbits; i++)
        begin
            hold(1'b1, 450);
            hold(1'b0, (i == 0 && bad_mark > 0) ? bad_mark : (w[i] ? 1050 : 450));
        end
        hold(1'b1, 300);
    endtask
endmodule // irc_ir_link_model
